// file: hdl/lsd_pkg.sv
// Constants, types and bus carriers of the display scan driver
package lsd_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [13:0] IDX_OUTPUT_CONTROL = 14'h008f;
  localparam logic [13:0] IDX_DISP_DRIVE_CTRL = 14'h0093;
  localparam logic [13:0] IDX_PORT1_OUT_EN = 14'h0094;
  localparam logic [13:0] IDX_DRIVE_LEVEL_0 = 14'h0096;
  localparam logic [13:0] IDX_DRIVE_LEVEL_1 = 14'h0097;
  localparam logic [13:0] IDX_PORT0_OUT_EN = 14'h009c;
  localparam logic [13:0] IDX_PORT2_OUT_EN = 14'h00a3;
  localparam logic [13:0] IDX_PORT3_OUT_EN = 14'h00b3;
  localparam logic [13:0] IDX_SCAN_CONFIG = 14'h00c4;
  localparam logic [13:0] IDX_SCAN_STATUS = 14'h00c5;
  localparam logic [13:0] IDX_DISP_MEM_BASE = 14'h1000;
  localparam logic [13:0] IDX_DISP_MEM_LAST = 14'h101b;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int DDC_SCAN_ON_BIT = 7;
  localparam int DDC_KIND_BIT = 6;
  localparam int DDC_DUTY_LSB = 4;
  localparam int DDC_TRIM_LSB = 0;
  localparam int OC_DIVSEL_LSB = 2;
  localparam int OC_SCS_BIT = 1;
  localparam int OC_BIAS_BIT = 0;
  localparam int CFG_EXT_CLK_BIT = 0;
  localparam logic [7:0] DL1_MASK = 8'h3f;
  localparam logic [7:0] CFG_MASK = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] VLCD_BASE = 5'h11;
  localparam logic [1:0] DIV_100K = 2'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_HZ = 50000000;
  localparam int SCAN_HZ = 32768;
  localparam int FRAME_HZ = 64;
  localparam int FRAME_TICKS = SCAN_HZ / FRAME_HZ;
  localparam int LRC_DIV = MCLK_HZ / SCAN_HZ;

  // ----------------------------------------
  // Bus
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DUTY_8 = 2'b00,
    DUTY_6 = 2'b01,
    DUTY_5 = 2'b10,
    DUTY_4 = 2'b11
  } lsd_duty_t;

  typedef enum logic {
    SC_IDLE = 1'b0,
    SC_RUN  = 1'b1
  } lsd_scan_t;

  typedef struct packed {
    logic        awvalid;
    logic [15:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [15:0] araddr;
    logic        rready;
  } lsd_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } lsd_axi_rsp_t;

endpackage

// file: hdl/lsd_scan_driver.sv
// Segment/common display scan driver with AXI4-Lite registers
module lsd_scan_driver
  import lsd_pkg::*;
#(
  parameter int NUM_SEGS = 28,
  parameter int LRC_DIVIDE = LRC_DIV
) (
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire lsd_axi_req_t axi_req_i,
  output lsd_axi_rsp_t      axi_rsp_o,
  input  wire logic         ext_osc_i,
  output logic [31:0]       pin_en_o,
  output logic [31:0]       pin_led_o,
  output logic [95:0]       pin_lcd_level_o,
  output logic [31:0]       pin_is_com_o,
  output logic [4:0]        vlcd_num_o,
  output logic [1:0]        divider_sel_o,
  output logic              bias_third_o,
  output logic [13:0]       drive_level_o,
  output logic              strength_on_com_o,
  output logic              scan_active_o
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]  oc_q;
  logic [7:0]  ddc_q;
  logic [7:0]  ve_q [4];
  logic [7:0]  dl0_q;
  logic [7:0]  dl1_q;
  logic [7:0]  cfg_q;
  logic [7:0]  mem_q [NUM_SEGS];
  lsd_axi_rsp_t rsp_q;

  logic [13:0] wr_idx;
  logic [13:0] rd_idx;
  logic        wr_go;
  logic        rd_go;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_mem;
  logic [13:0] wr_mem_off;
  logic [4:0]  wr_seg;
  logic        wr_hit;
  logic        rd_hit;
  logic [7:0]  rd_data;

  assign wr_idx = axi_req_i.awaddr[15:2];
  assign rd_idx = axi_req_i.araddr[15:2];
  assign wr_go = axi_req_i.awvalid & axi_req_i.wvalid & ~rsp_q.bvalid & ~rsp_q.awready;
  assign rd_go = axi_req_i.arvalid & ~rsp_q.rvalid & ~rsp_q.arready;
  assign wr_fire = rsp_q.awready;
  assign rd_fire = rsp_q.arready;
  assign wr_mem = wr_idx >= IDX_DISP_MEM_BASE && wr_idx <= IDX_DISP_MEM_LAST;
  assign wr_mem_off = wr_idx - IDX_DISP_MEM_BASE;
  assign wr_seg = wr_mem_off[4:0];
  assign axi_rsp_o = rsp_q;

  always_comb begin
    wr_hit = wr_mem;
    case (wr_idx)
      IDX_OUTPUT_CONTROL, IDX_DISP_DRIVE_CTRL, IDX_PORT0_OUT_EN, IDX_PORT1_OUT_EN,
      IDX_PORT2_OUT_EN, IDX_PORT3_OUT_EN, IDX_DRIVE_LEVEL_0, IDX_DRIVE_LEVEL_1,
      IDX_SCAN_CONFIG: wr_hit = 1'b1;
      default: ;
    endcase
  end

  // ----------------------------------------
  // Bus handshakes
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q.awready <= wr_go;
      rsp_q.wready <= wr_go;
      rsp_q.arready <= rd_go;
      if (wr_fire) begin
        rsp_q.bvalid <= 1'b1;
        rsp_q.bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req_i.bready) begin
        rsp_q.bvalid <= 1'b0;
      end
      if (rd_fire) begin
        rsp_q.rvalid <= 1'b1;
        rsp_q.rdata <= {24'h000000, rd_data};
        rsp_q.rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req_i.rready) begin
        rsp_q.rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      oc_q <= REG_RESET;
      ddc_q <= REG_RESET;
      dl0_q <= REG_RESET;
      dl1_q <= REG_RESET;
      cfg_q <= REG_RESET;
      for (int i = 0; i < 4; i++) begin
        ve_q[i] <= REG_RESET;
      end
    end else if (wr_fire && axi_req_i.wstrb[0]) begin
      case (wr_idx)
        IDX_OUTPUT_CONTROL: oc_q <= axi_req_i.wdata[7:0];
        IDX_DISP_DRIVE_CTRL: ddc_q <= axi_req_i.wdata[7:0];
        IDX_PORT0_OUT_EN: ve_q[0] <= axi_req_i.wdata[7:0];
        IDX_PORT1_OUT_EN: ve_q[1] <= axi_req_i.wdata[7:0];
        IDX_PORT2_OUT_EN: ve_q[2] <= axi_req_i.wdata[7:0];
        IDX_PORT3_OUT_EN: ve_q[3] <= axi_req_i.wdata[7:0];
        IDX_DRIVE_LEVEL_0: dl0_q <= axi_req_i.wdata[7:0];
        IDX_DRIVE_LEVEL_1: dl1_q <= axi_req_i.wdata[7:0] & DL1_MASK;
        IDX_SCAN_CONFIG: cfg_q <= axi_req_i.wdata[7:0] & CFG_MASK;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Display memory
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (wr_fire && axi_req_i.wstrb[0] && wr_mem) begin
      mem_q[wr_seg] <= axi_req_i.wdata[7:0];
    end
  end

  // ----------------------------------------
  // Scan tick sources
  // ----------------------------------------
  logic [2:0]  ext_sync_q;
  logic        ext_filt_q;
  logic        ext_tick_q;
  logic [11:0] lrc_cnt_q;
  logic        lrc_tick_q;
  logic        tick;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ext_sync_q <= 3'h0;
      ext_filt_q <= 1'b0;
      ext_tick_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_osc_i};
      if (ext_sync_q[1] == ext_sync_q[2]) begin
        ext_filt_q <= ext_sync_q[2];
      end
      ext_tick_q <= (ext_sync_q[1] == ext_sync_q[2]) & ext_sync_q[2] & ~ext_filt_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lrc_cnt_q <= 12'h000;
      lrc_tick_q <= 1'b0;
    end else if (lrc_cnt_q == 12'(LRC_DIVIDE - 1)) begin
      lrc_cnt_q <= 12'h000;
      lrc_tick_q <= 1'b1;
    end else begin
      lrc_cnt_q <= lrc_cnt_q + 12'h001;
      lrc_tick_q <= 1'b0;
    end
  end

  assign tick = cfg_q[CFG_EXT_CLK_BIT] ? ext_tick_q : lrc_tick_q;

  // ----------------------------------------
  // Frame settings
  // ----------------------------------------
  lsd_duty_t sh_duty_q;
  logic      sh_scs_q;
  logic      sh_bias_q;
  logic      sh_kind_q;
  lsd_scan_t state_q;
  logic [7:0] slot_len;
  logic [7:0] lead_len;
  logic [3:0] com_cnt;
  logic [3:0] first_com;
  logic [4:0] first_seg;
  logic       frame_end;

  always_comb begin
    case (sh_duty_q)
      DUTY_8: begin
        slot_len = 8'(FRAME_TICKS / 8);
        com_cnt = 4'h8;
        first_com = 4'h0;
        first_seg = 5'h04;
      end
      DUTY_6: begin
        slot_len = 8'(FRAME_TICKS / 6);
        com_cnt = 4'h6;
        first_com = 4'h2;
        first_seg = 5'h02;
      end
      DUTY_5: begin
        slot_len = 8'(FRAME_TICKS / 5);
        com_cnt = 4'h5;
        first_com = 4'h3;
        first_seg = 5'h01;
      end
      default: begin
        slot_len = 8'(FRAME_TICKS / 4);
        com_cnt = 4'h4;
        first_com = sh_scs_q ? 4'h0 : 4'h4;
        first_seg = sh_scs_q ? 5'h04 : 5'h00;
      end
    endcase
    lead_len = slot_len >> 4;
  end

  // ----------------------------------------
  // Scan sequencer
  // ----------------------------------------
  logic [7:0] slot_cnt_q;
  logic [3:0] com_pos_q;
  logic       phase_q;
  logic [2:0] cur_com;
  logic       lead;
  logic       run;

  assign run = state_q == SC_RUN;
  assign frame_end = run & tick & (slot_cnt_q == slot_len - 8'h01) & (com_pos_q == com_cnt - 4'h1);
  assign cur_com = 3'(first_com + com_pos_q);
  assign lead = slot_cnt_q < lead_len;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q <= SC_IDLE;
    end else begin
      case (state_q)
        SC_IDLE: if (ddc_q[DDC_SCAN_ON_BIT]) state_q <= SC_RUN;
        SC_RUN: if (!ddc_q[DDC_SCAN_ON_BIT]) state_q <= SC_IDLE;
        default: state_q <= SC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sh_duty_q <= DUTY_8;
      sh_scs_q <= 1'b0;
      sh_bias_q <= 1'b0;
      sh_kind_q <= 1'b0;
    end else if (!run || frame_end) begin
      sh_duty_q <= lsd_duty_t'(ddc_q[DDC_DUTY_LSB+:2]);
      sh_scs_q <= oc_q[OC_SCS_BIT];
      sh_bias_q <= oc_q[OC_BIAS_BIT];
      sh_kind_q <= ddc_q[DDC_KIND_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || !run) begin
      slot_cnt_q <= 8'h00;
      com_pos_q <= 4'h0;
      phase_q <= 1'b0;
    end else if (tick) begin
      if (slot_cnt_q == slot_len - 8'h01) begin
        slot_cnt_q <= 8'h00;
        if (com_pos_q == com_cnt - 4'h1) begin
          com_pos_q <= 4'h0;
          phase_q <= ~phase_q;
        end else begin
          com_pos_q <= com_pos_q + 4'h1;
        end
      end else begin
        slot_cnt_q <= slot_cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  logic [31:0] en_d;
  logic [31:0] led_d;
  logic [95:0] lvl_d;
  logic [31:0] com_d;
  logic [2:0]  vmax;

  assign vmax = sh_bias_q ? 3'h3 : 3'h4;

  for (genvar p = 0; p < 32; p++) begin : g_pin
    logic       has_c;
    logic [3:0] c;
    logic       is_com;
    logic       is_seg;
    logic       sel;
    logic       lit;
    logic [2:0] a;
    always_comb begin
      has_c = (p < 4) || (p >= NUM_SEGS);
      c = (p < 4) ? 4'(3 - p) : 4'(p - NUM_SEGS + 4);
      is_com = has_c && c >= first_com && c < first_com + com_cnt;
      is_seg = p < NUM_SEGS && 5'(p) >= first_seg && !is_com;
      sel = is_com && c[2:0] == cur_com;
      lit = (p < NUM_SEGS) ? mem_q[p % NUM_SEGS][cur_com] : 1'b0;
      en_d[p] = run && ve_q[p / 8][p % 8] && (is_com || is_seg);
      com_d[p] = is_com;
      if (is_com) begin
        a = sel ? vmax : 3'h1;
      end else begin
        a = lit ? 3'h0 : 3'h2;
      end
      if (phase_q) begin
        a = vmax - a;
      end
      led_d[p] = en_d[p] && sh_kind_q && (is_com ? sel : lit);
      lvl_d[3*p+:3] = (en_d[p] && !sh_kind_q) ? a : 3'h0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pin_en_o <= '0;
      pin_led_o <= '0;
      pin_lcd_level_o <= '0;
      pin_is_com_o <= '0;
      vlcd_num_o <= VLCD_BASE;
      divider_sel_o <= DIV_100K;
      bias_third_o <= 1'b0;
      drive_level_o <= '0;
      strength_on_com_o <= 1'b1;
      scan_active_o <= 1'b0;
    end else begin
      pin_en_o <= en_d;
      pin_led_o <= led_d;
      pin_lcd_level_o <= lvl_d;
      pin_is_com_o <= com_d;
      vlcd_num_o <= VLCD_BASE + {1'b0, ddc_q[DDC_TRIM_LSB+:4]};
      divider_sel_o <= (run && lead) ? DIV_100K : oc_q[OC_DIVSEL_LSB+:2];
      bias_third_o <= sh_bias_q;
      drive_level_o <= {dl1_q[5:0], dl0_q};
      strength_on_com_o <= ~sh_kind_q;
      scan_active_o <= run;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [13:0] rd_mem_off;
  assign rd_mem_off = rd_idx - IDX_DISP_MEM_BASE;

  always_comb begin
    rd_hit = 1'b1;
    rd_data = 8'h00;
    case (rd_idx)
      IDX_OUTPUT_CONTROL: rd_data = oc_q;
      IDX_DISP_DRIVE_CTRL: rd_data = ddc_q;
      IDX_PORT0_OUT_EN: rd_data = ve_q[0];
      IDX_PORT1_OUT_EN: rd_data = ve_q[1];
      IDX_PORT2_OUT_EN: rd_data = ve_q[2];
      IDX_PORT3_OUT_EN: rd_data = ve_q[3];
      IDX_DRIVE_LEVEL_0: rd_data = dl0_q;
      IDX_DRIVE_LEVEL_1: rd_data = dl1_q;
      IDX_SCAN_CONFIG: rd_data = cfg_q;
      IDX_SCAN_STATUS: rd_data = {run, phase_q, sh_kind_q, sh_duty_q, cur_com};
      default: begin
        if (rd_idx >= IDX_DISP_MEM_BASE && rd_idx <= IDX_DISP_MEM_LAST) begin
          rd_data = mem_q[rd_mem_off[4:0]];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

endmodule

// file: verif/lsd_scan_monitor.sv
// Port-level assertions for the display scan driver
module lsd_scan_monitor
  import lsd_pkg::*;
(
  input wire logic         mclk_i,
  input wire logic         srst_i,
  input wire lsd_axi_req_t axi_req_i,
  input wire lsd_axi_rsp_t axi_rsp_o,
  input wire logic [31:0]  pin_en_o,
  input wire logic [31:0]  pin_led_o,
  input wire logic [95:0]  pin_lcd_level_o,
  input wire logic [31:0]  pin_is_com_o,
  input wire logic [4:0]   vlcd_num_o,
  input wire logic [1:0]   divider_sel_o,
  input wire logic         bias_third_o,
  input wire logic [13:0]  drive_level_o,
  input wire logic         scan_active_o
);
  // --------
  // Register shadow
  // --------
  logic [7:0]  ddc_q;
  logic [7:0]  oc_q;
  logic [13:0] dl_q;
  logic [31:0] en_q;
  logic [7:0]  wd;
  logic [2:0]  lvl_max;
  assign wd = axi_req_i.wdata[7:0];
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ddc_q <= REG_RESET;
      oc_q  <= REG_RESET;
      dl_q  <= 14'h0;
      en_q  <= 32'h0;
    end else if (axi_rsp_o.awready && axi_req_i.wstrb[0]) begin
      case (axi_req_i.awaddr[15:2])
        IDX_DISP_DRIVE_CTRL: ddc_q <= wd;
        IDX_OUTPUT_CONTROL: oc_q <= wd;
        IDX_DRIVE_LEVEL_0: dl_q[7:0] <= wd;
        IDX_DRIVE_LEVEL_1: dl_q[13:8] <= wd[5:0];
        IDX_PORT0_OUT_EN: en_q[7:0] <= wd;
        IDX_PORT1_OUT_EN: en_q[15:8] <= wd;
        IDX_PORT2_OUT_EN: en_q[23:16] <= wd;
        IDX_PORT3_OUT_EN: en_q[31:24] <= wd;
        default: ;
      endcase
    end
  end
  always_comb begin
    lvl_max = 3'h0;
    for (int p = 0; p < 32; p++)
      if (pin_lcd_level_o[3*p +: 3] > lvl_max)
        lvl_max = pin_lcd_level_o[3*p +: 3];
  end
  // --------
  // Checks
  // --------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  sequence s_wr_taken;
    axi_rsp_o.awready && axi_rsp_o.wready;
  endsequence
  sequence s_wr_answer;
    axi_rsp_o.bvalid && !axi_rsp_o.awready;
  endsequence
  chk_wr_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write response late");
  chk_rd_answer: assert property (axi_rsp_o.arready |=> axi_rsp_o.rvalid)
    else $error("read response late");
  chk_scan_start: assert property ($rose(ddc_q[7]) |-> ##[1:4] scan_active_o)
    else $error("scan did not start");
  chk_scan_stop: assert property ($fell(ddc_q[7]) |-> ##[1:4] !scan_active_o)
    else $error("scan did not stop");
  chk_vlcd_trim: assert property ($stable(ddc_q[3:0]) [*3] |-> vlcd_num_o == VLCD_BASE + 5'(ddc_q[3:0]))
    else $error("panel voltage wrong");
  chk_drive_level: assert property ($stable(dl_q) [*3] |-> drive_level_o == dl_q)
    else $error("drive level wrong");
  chk_pin_enable: assert property ($stable(en_q) [*3] |-> (pin_en_o & ~en_q) == 32'h0)
    else $error("disabled pin driven");
  chk_divider_sel: assert property ($stable(oc_q[3:2]) [*3] |-> divider_sel_o inside {DIV_100K, oc_q[3:2]})
    else $error("divider code wrong");
  chk_mode_excl: assert property (|pin_led_o |-> pin_lcd_level_o == 96'h0)
    else $error("LED and LCD drive together");
  chk_bias_range: assert property ($stable(bias_third_o) |-> lvl_max <= (bias_third_o ? 3'h3 : 3'h4))
    else $error("bias level out of range");
  chk_one_com: assert property ($onehot0(pin_led_o & pin_is_com_o))
    else $error("two commons active");
  chk_com_map: assert property (scan_active_o [*2] |-> pin_is_com_o inside
    {32'hf000000f, 32'hf0000003, 32'hf0000001, 32'hf0000000, 32'h0000000f})
    else $error("common pin set wrong");
endmodule

bind lsd_scan_driver lsd_scan_monitor u_mon (
  .mclk_i, .srst_i, .axi_req_i, .axi_rsp_o, .pin_en_o, .pin_led_o, .pin_lcd_level_o,
  .pin_is_com_o, .vlcd_num_o, .divider_sel_o, .bias_third_o, .drive_level_o, .scan_active_o);

// file: verif/lsd_panel_model.sv
// LED matrix model reporting the lit common and the length of the slot that ended when it lit
module lsd_panel_model
  import lsd_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic [31:0] pin_led_i,
  input  wire logic [31:0] pin_is_com_i,
  output logic             step_o,
  output logic [2:0]       com_o,
  output int               slot_o
);
  logic [31:0] lit;
  logic [31:0] lit_q;
  int          run;
  assign lit = pin_led_i & pin_is_com_i;
  always @(posedge mclk_i) begin
    lit_q  <= lit;
    run    <= run + 1;
    step_o <= 1'b0;
    if (lit != lit_q && lit != 32'h0) begin
      step_o <= 1'b1;
      slot_o <= run;
      run    <= 1;
      for (int p = 0; p < 32; p++)
        if (lit[p])
          com_o <= (p < 4) ? 3'(3 - p) : 3'(p - 24);
    end
  end
endmodule

// file: verif/lsd_scan_driver_tb_top.sv
// Self-checking bench for the display scan driver
module lsd_scan_driver_tb_top
  import lsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 4;
  localparam int EXT = 6;
  logic         ext_osc = 1'b0;
  logic [7:0]   segv;
  int           ext_div = 0, since = 0;
  logic         mclk_i;
  logic         srst_i;
  lsd_axi_req_t req;
  lsd_axi_rsp_t rsp;
  logic [31:0]  pin_en, pin_led, pin_com;
  logic [95:0]  lvl;
  logic [4:0]   vlcd;
  logic [1:0]   dsel;
  logic [13:0]  dlev;
  logic         bias3, str_com, scan_act, step, track;
  logic [2:0]   com, first_com, last_com, prev_com;
  logic [15:0]  lfsr;
  logic [7:0]   v;
  logic [33:0]  rdq[$];
  logic [1:0]   bq[$];
  int           slot, exp_slot, nsteps, cyc, bad_count = 0, tests_run = 0;
  logic [13:0]  ports[4] = '{IDX_PORT0_OUT_EN, IDX_PORT1_OUT_EN, IDX_PORT2_OUT_EN, IDX_PORT3_OUT_EN};
  logic [13:0]  regs[4] = '{IDX_OUTPUT_CONTROL, IDX_DISP_DRIVE_CTRL, IDX_DRIVE_LEVEL_0, IDX_DRIVE_LEVEL_1};
  logic [1:0]   c_duty[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [2:0]   c_first[5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h0};
  logic [31:0]  c_mask[5] = '{32'hf000000f, 32'hf0000003, 32'hf0000001, 32'hf0000000, 32'h0000000f};
  int           c_n[5] = '{8, 6, 5, 4, 4};
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  lsd_scan_driver #(.LRC_DIVIDE(DIV)) dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .axi_req_i(req), .axi_rsp_o(rsp), .ext_osc_i(ext_osc),
    .pin_en_o(pin_en), .pin_led_o(pin_led), .pin_lcd_level_o(lvl), .pin_is_com_o(pin_com),
    .vlcd_num_o(vlcd), .divider_sel_o(dsel), .bias_third_o(bias3), .drive_level_o(dlev),
    .strength_on_com_o(str_com), .scan_active_o(scan_act));
  lsd_panel_model u_panel (
    .mclk_i(mclk_i), .pin_led_i(pin_led), .pin_is_com_i(pin_com), .step_o(step), .com_o(com), .slot_o(slot));
  // External oscillator stand-in, one rising edge every EXT clocks
  always @(posedge mclk_i) begin
    ext_div <= (ext_div == 2) ? 0 : ext_div + 1;
    if (ext_div == 2)
      ext_osc <= ~ext_osc;
  end
  // --------
  // Tasks
  // --------
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp_pin(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    cmp_pin(got, exp);
  endtask
  task automatic wr(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] r);
    logic a;
    logic w;
    a = 1'b1;
    w = 1'b1;
    bq.push_back(r);
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.awaddr  <= {idx, 2'b00};
    req.wdata   <= {24'h0, d};
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    while (a || w) begin
      @(posedge mclk_i);
      if (rsp.awready) begin
        a = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge mclk_i); while (!rsp.bvalid);
    req.bready <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [13:0] idx, input logic [7:0] d, input logic [1:0] r);
    rdq.push_back({r, 24'h0, d});
    req.arvalid <= 1'b1;
    req.araddr  <= {idx, 2'b00};
    req.rready  <= 1'b1;
    do @(posedge mclk_i); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge mclk_i); while (!rsp.rvalid);
    req.rready <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // --------
  // Result watcher and timeout
  // --------
  always @(posedge mclk_i) begin
    if (rsp.rvalid && req.rready && rdq.size() > 0)
      cmp_bus({rsp.rresp, rsp.rdata}, rdq.pop_front());
    if (rsp.bvalid && req.bready && bq.size() > 0)
      cmp_bus({32'h0, rsp.bresp}, {32'h0, bq.pop_front()});
    since++;
    if (step && track) begin
      nsteps++;
      since = 0;
      cmp_pin({31'h0, com}, {31'h0, (nsteps == 1 || prev_com == last_com) ? first_com : 3'(prev_com + 3'h1)});
      cmp_pin({32'h0, dsel}, {32'h0, DIV_100K});
      cmp_pin({33'h0, pin_led[4]}, {33'h0, segv[com]});
      if (nsteps > 2)
        cmp_pin(34'(slot), 34'(exp_slot));
      prev_com = com;
    end
    if (track && nsteps > 0 && since == 100)
      cmp_pin({32'h0, dsel}, 34'h3);
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      test_done();
    end
  end
  // --------
  // Main sequence
  // --------
  initial begin
    req = '0;
    srst_i = 1'b1;
    track = 1'b0;
    cyc = 0;
    lfsr = 16'hecb8;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    for (int i = 0; i < 4; i++) begin
      rd(ports[i], 8'h00, RESP_OKAY);
      rd(regs[i], 8'h00, RESP_OKAY);
    end
    rd(14'h0200, 8'h00, RESP_SLVERR);
    wr(14'h0200, 8'h5a, RESP_SLVERR);
    rd(IDX_SCAN_CONFIG, 8'h00, RESP_OKAY);
    rd(IDX_SCAN_STATUS, 8'h00, RESP_OKAY);
    cmp_pin({29'h0, vlcd}, 34'h11);
    $display("test reset_map done");
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      v = (i == 0) ? 8'h0f : lfsr[7:0];
      wr(ports[i], v, RESP_OKAY);
      rd(ports[i], v, RESP_OKAY);
      wr(IDX_DISP_DRIVE_CTRL, {4'h0, v[3:0]}, RESP_OKAY);
      cmp_pin({29'h0, vlcd}, {29'h0, VLCD_BASE + 5'(v[3:0])});
      wr(IDX_DRIVE_LEVEL_0, v, RESP_OKAY);
      wr(IDX_DRIVE_LEVEL_1, ~v, RESP_OKAY);
      rd(IDX_DRIVE_LEVEL_1, ~v & DL1_MASK, RESP_OKAY);
      cmp_pin({20'h0, dlev}, {20'h0, ~v[5:0], v});
      wr(IDX_OUTPUT_CONTROL, {4'h0, 2'(i), 2'h0}, RESP_OKAY);
      cmp_pin({32'h0, dsel}, {32'h0, 2'(i)});
    end
    lfsr = next_rand(lfsr);
    segv = lfsr[7:0];
    wr(IDX_DISP_MEM_BASE + 14'h0004, segv, RESP_OKAY);
    rd(IDX_DISP_MEM_BASE + 14'h0004, segv, RESP_OKAY);
    $display("test settings done");
    for (int i = 0; i < 4; i++)
      wr(ports[i], 8'hff, RESP_OKAY);
    for (int k = 0; k < 5; k++) begin
      first_com = c_first[k];
      last_com = (k == 4) ? 3'h3 : 3'h7;
      exp_slot = FRAME_TICKS / c_n[k] * ((k == 0) ? EXT : DIV);
      nsteps = 0;
      wr(IDX_SCAN_CONFIG, {7'h0, k == 0}, RESP_OKAY);
      wr(IDX_OUTPUT_CONTROL, {4'h0, 2'h3, k == 4, 1'b0}, RESP_OKAY);
      track = 1'b1;
      wr(IDX_DISP_DRIVE_CTRL, {2'h3, c_duty[k], 4'h0}, RESP_OKAY);
      repeat (3000) @(posedge mclk_i);
      track = 1'b0;
      cmp_pin({2'h0, pin_com}, {2'h0, c_mask[k]});
      cmp_pin({33'h0, scan_act}, 34'h1);
      cmp_pin({33'h0, str_com}, 34'h0);
      cmp_pin(34'(nsteps > 4), 34'h1);
      wr(IDX_DISP_DRIVE_CTRL, 8'h00, RESP_OKAY);
      repeat (4) @(posedge mclk_i);
      cmp_pin({33'h0, scan_act}, 34'h0);
      $display("test led duty %0d done", k);
    end
    wr(ports[2], 8'h0f, RESP_OKAY);
    wr(IDX_OUTPUT_CONTROL, 8'h01, RESP_OKAY);
    wr(IDX_DISP_DRIVE_CTRL, 8'hb7, RESP_OKAY);
    repeat (3000) @(posedge mclk_i);
    cmp_pin({2'h0, pin_led}, 34'h0);
    cmp_pin({33'h0, bias3}, 34'h1);
    cmp_pin({33'h0, str_com}, 34'h1);
    cmp_pin({29'h0, vlcd}, 34'h18);
    cmp_pin({2'h0, pin_en}, 34'hff0fffff);
    cmp_pin(34'(lvl[86:84]) + 34'(lvl[89:87]) + 34'(lvl[92:90]) + 34'(lvl[95:93]), 34'h6);
    wr(IDX_DISP_DRIVE_CTRL, 8'h87, RESP_OKAY);
    cmp_pin({2'h0, pin_com}, 34'hf0000000);
    repeat (2200) @(posedge mclk_i);
    cmp_pin({2'h0, pin_com}, 34'hf000000f);
    $display("test lcd done");
    test_done();
  end
endmodule
